/* File: rtl/sbl_loader.sv */
// bootstrap serial download loader with boot rom map and emulation entry
`timescale 1ns/1ps
`default_nettype none
module sbl_loader
(
   input wire logic ref_clk_in, // 125 MHz system clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic mode_a_in, // mode select pin a
   input wire logic mode_b_in, // mode select pin b
   input wire logic rxd_in, // serial receive pin
   output logic txd_out, // serial transmit pin
   output logic jump_valid_out, // loader finished, jump taken
   output logic [15:0] jump_addr_out, // execution start address
   output logic [9:0] load_count_out, // bytes stored so far
   input wire logic [8:0] ram_rd_addr_in, // ram read address
   output logic [7:0] ram_rd_data_out, // ram read data
   input wire logic mode_wr_in, // write mode register
   input wire logic [7:0] mode_wdata_in, // mode register write data
   output logic [7:0] mode_rdata_out, // mode register read data
   input wire logic [15:0] cpu_addr_in, // cpu read address
   input wire logic [7:0] boot_rom_data_in, // boot rom data
   input wire logic [7:0] user_rom_data_in, // user rom data
   output logic boot_rom_sel_out, // boot rom selected
   output logic [7:0] cpu_rdata_out, // selected rom data
   output logic emulation_mode_out, // eprom emulation active
   input wire logic emulation_output_enable_pin_in, // emulated oe, low
   input wire logic [7:0] emu_array_data_in, // eprom array data
   output logic [7:0] emu_data_out, // data pin output
   output logic emu_data_oe_out // data pins driven
);
   typedef enum logic [2:0] {
      S_SYNC_WAIT, S_SYNC_LOW, S_SYNC_BITS, S_DL_IDLE, S_DL_BITS, S_DONE
   } sbl_state_type;

   sbl_state_type state_ff;
   logic rx_s1_ff, rx_s2_ff, rx_d_ff;
   logic ma_s1_ff, ma_s2_ff, mb_s1_ff, mb_s2_ff, oe_s1_ff, oe_s2_ff;
   logic [17:0] cnt_ff, smp_at_ff, idle_ff, tmo_ff;
   logic [10:0] period_ff, nxt_period;
   logic [7:0] tmo_bits, shreg_ff;
   logic [3:0] idx_ff;
   logic dflt_ff, eeprom_cls, sample, fall, rise;
   logic bootstrap_ff, map_en_ff, modes_low, echo_wr;
   logic [9:0] count_ff;
   logic [7:0] ram [0:511];

   assign modes_low = !ma_s2_ff && !mb_s2_ff;
   assign fall = rx_d_ff && !rx_s2_ff;
   assign rise = !rx_d_ff && rx_s2_ff;
   assign sample = cnt_ff == smp_at_ff;

   // pins pass two flops; the mode pins stay live during reset
   always_ff @(posedge ref_clk_in)
   begin
      rx_s1_ff <= rxd_in;
      rx_s2_ff <= rx_s1_ff;
      ma_s1_ff <= mode_a_in;
      ma_s2_ff <= ma_s1_ff;
      mb_s1_ff <= mode_b_in;
      mb_s2_ff <= mb_s1_ff;
      oe_s1_ff <= emulation_output_enable_pin_in;
      oe_s2_ff <= oe_s1_ff;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
         rx_d_ff <= 1'b1;
      else
         rx_d_ff <= rx_s2_ff;
   end

   // width of the first low pulse picks the rate and timeout
   always_comb
   begin
      eeprom_cls = 1'b0;
      if (cnt_ff < sbl_pkg::THR_DEFAULT)
      begin
         nxt_period = sbl_pkg::DIV_DEFAULT; // RULE_12
         tmo_bits = sbl_pkg::TMO_BITS_FF;
      end
      else if (cnt_ff < sbl_pkg::THR_5208)
      begin
         nxt_period = sbl_pkg::DIV_5208; // RULE_13
         tmo_bits = sbl_pkg::TMO_BITS_5208;
      end
      else if (cnt_ff < sbl_pkg::THR_3906)
      begin
         nxt_period = sbl_pkg::DIV_3906; // RULE_13
         tmo_bits = sbl_pkg::TMO_BITS_3906;
      end
      else if (cnt_ff < sbl_pkg::THR_9600)
      begin
         nxt_period = sbl_pkg::DIV_9600; // RULE_13
         tmo_bits = sbl_pkg::TMO_BITS_F0;
      end
      else if (cnt_ff < sbl_pkg::THR_1200)
      begin
         nxt_period = sbl_pkg::DIV_1200; // RULE_12
         tmo_bits = sbl_pkg::TMO_BITS_FF;
      end
      else
      begin
         nxt_period = sbl_pkg::DIV_DEFAULT;
         tmo_bits = sbl_pkg::TMO_BITS_FF;
         eeprom_cls = 1'b1; // RULE_15
      end
   end

   assign echo_wr = state_ff == S_DL_BITS && sample
      && idx_ff == sbl_pkg::FRAME_LAST && rx_s2_ff
      && count_ff < sbl_pkg::MAX_LOAD;

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         state_ff <= S_SYNC_WAIT;
         cnt_ff <= 18'h00000;
         smp_at_ff <= 18'h00000;
         idle_ff <= 18'h00000;
         tmo_ff <= 18'h00000;
         period_ff <= sbl_pkg::DIV_DEFAULT;
         shreg_ff <= 8'h00;
         idx_ff <= 4'h0;
         dflt_ff <= 1'b0;
         count_ff <= 10'h000;
         jump_valid_out <= 1'b0;
         jump_addr_out <= 16'h0000;
      end
      else
      begin
         cnt_ff <= cnt_ff + 18'h00001;
         unique case (state_ff)
            S_SYNC_WAIT:
            begin
               // no time limit before the sync character
               cnt_ff <= 18'h00000; // RULE_03
               if (bootstrap_ff && fall)
                  state_ff <= S_SYNC_LOW;
            end
            S_SYNC_LOW:
               if (rise)
               begin
                  period_ff <= nxt_period; // RULE_14
                  // widen first so the product cannot wrap at 11 bits
                  tmo_ff <= 18'(tmo_bits) * 18'(nxt_period);
                  dflt_ff <= nxt_period == sbl_pkg::DIV_DEFAULT;
                  if (eeprom_cls)
                  begin
                     jump_valid_out <= 1'b1; // RULE_15
                     jump_addr_out <= sbl_pkg::EEPROM_BASE;
                     state_ff <= S_DONE;
                  end
                  else if (nxt_period == sbl_pkg::DIV_DEFAULT)
                  begin
                     // bit 0 already seen high; decode bits 1..7
                     shreg_ff <= 8'h80;
                     idx_ff <= 4'h2;
                     smp_at_ff <= 18'({nxt_period, 1'b0})
                        + 18'(nxt_period >> 1);
                     state_ff <= S_SYNC_BITS;
                  end
                  else
                  begin
                     // other syncs are not decoded, only waited out
                     idx_ff <= sbl_pkg::FRAME_LAST;
                     smp_at_ff <= 18'({nxt_period, 3'b000})
                        + 18'(nxt_period) + 18'(nxt_period >> 1);
                     state_ff <= S_SYNC_BITS;
                  end
               end
            S_SYNC_BITS:
               if (sample)
               begin
                  smp_at_ff <= smp_at_ff + 18'(period_ff);
                  idx_ff <= idx_ff + 4'h1;
                  if (idx_ff != sbl_pkg::FRAME_LAST)
                     shreg_ff <= {rx_s2_ff, shreg_ff[7:1]};
                  else if (dflt_ff && shreg_ff == sbl_pkg::CHAR_JUMP_RAM)
                  begin
                     jump_valid_out <= 1'b1; // RULE_17
                     jump_addr_out <= sbl_pkg::RAM_BASE;
                     state_ff <= S_DONE;
                  end
                  else
                  begin
                     idle_ff <= 18'h00000; // RULE_03
                     state_ff <= S_DL_IDLE;
                  end
               end
            S_DL_IDLE:
               if (fall)
               begin
                  cnt_ff <= 18'h00000;
                  idx_ff <= 4'h0;
                  smp_at_ff <= 18'(period_ff >> 1);
                  state_ff <= S_DL_BITS;
               end
               else if (idle_ff >= tmo_ff - 18'h00001)
               begin
                  jump_valid_out <= 1'b1; // RULE_16
                  jump_addr_out <= sbl_pkg::RAM_BASE;
                  state_ff <= S_DONE;
               end
               else
                  idle_ff <= idle_ff + 18'h00001; // RULE_02
            S_DL_BITS:
               if (sample)
               begin
                  smp_at_ff <= smp_at_ff + 18'(period_ff);
                  idx_ff <= idx_ff + 4'h1;
                  idle_ff <= 18'h00000;
                  if (idx_ff == 4'h0 && rx_s2_ff)
                     state_ff <= S_DL_IDLE; // glitch, not a start bit
                  else if (idx_ff == sbl_pkg::FRAME_LAST)
                  begin
                     // a framing error drops the character
                     state_ff <= S_DL_IDLE;
                     if (echo_wr)
                        count_ff <= count_ff + 10'h001; // RULE_18
                     if (echo_wr && count_ff == sbl_pkg::MAX_LOAD - 10'h001)
                     begin
                        jump_valid_out <= 1'b1; // RULE_18
                        jump_addr_out <= sbl_pkg::RAM_BASE;
                        state_ff <= S_DONE;
                     end
                  end
                  else if (idx_ff != 4'h0)
                     shreg_ff <= {rx_s2_ff, shreg_ff[7:1]};
               end
            S_DONE:
               cnt_ff <= 18'h00000;
         endcase
      end
   end

   // download memory, consecutive from the ram base
   always_ff @(posedge ref_clk_in)
   begin
      if (echo_wr)
         ram[count_ff[8:0]] <= shreg_ff; // RULE_18
      ram_rd_data_out <= ram[ram_rd_addr_in];
   end

   assign load_count_out = count_ff;

   // echo goes in the data register and waits behind the shifter
   sbl_sci_tx u_tx
   (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .period_in(period_ff),
      .wr_in(echo_wr), // RULE_10
      .wdata_in(shreg_ff),
      .hold_empty_out(),
      .busy_out(),
      .txd_out(txd_out)
   );

   // bootstrap is caught from the mode pins while reset is held
   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         bootstrap_ff <= modes_low;
         map_en_ff <= modes_low; // RULE_07
      end
      else if (mode_wr_in && bootstrap_ff)
         map_en_ff <= mode_wdata_in[sbl_pkg::MAP_EN_BIT]; // RULE_07
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         mode_rdata_out <= 8'h00;
         boot_rom_sel_out <= 1'b0;
         cpu_rdata_out <= 8'h00;
      end
      else
      begin
         mode_rdata_out <= 8'(map_en_ff) << sbl_pkg::MAP_EN_BIT;
         boot_rom_sel_out <= map_en_ff
            && cpu_addr_in >= sbl_pkg::BOOT_ROM_LO
            && cpu_addr_in <= sbl_pkg::BOOT_ROM_HI; // RULE_08
         cpu_rdata_out <= (map_en_ff
            && cpu_addr_in >= sbl_pkg::BOOT_ROM_LO
            && cpu_addr_in <= sbl_pkg::BOOT_ROM_HI)
            ? boot_rom_data_in : user_rom_data_in; // RULE_08
      end
   end

   // emulation follows the reset pin itself, so it runs during reset
   always_ff @(posedge ref_clk_in)
   begin
      emulation_mode_out <= !nrst_in && modes_low; // RULE_05
      emu_data_oe_out <= !nrst_in && modes_low && !oe_s2_ff; // RULE_06
      emu_data_out <= emu_array_data_in;
   end
endmodule : sbl_loader
`default_nettype wire

/* File: rtl/sbl_pkg.sv */
// constants shared by the serial boot download loader
// What this block does
// [RULE_01] host sends sync plus 256 bytes originally
// [RULE_02] four idle character times end the download; code uses 4.9 for F0 and 17.3 or 13 for the FD rates
// [RULE_03] timeout armed only after the sync character
// [RULE_04] host keeps characters close or uses 1200
// [RULE_05] reset low with modes low: emulation mode
// [RULE_06] emulation data pins steered by output enable
// [RULE_07] map enable: resets 1, writable only bootstrap
// [RULE_08] mapped boot rom overrides user rom reads
// [RULE_09] transmitter holds one shifting, one waiting
// [RULE_10] echo every received download character; code skips characters with a low stop bit
// [RULE_11] host streams without waiting for echoes
// [RULE_12] sync FF: default or 1200, four chars
// [RULE_13] F0 9600 4.9 chars; FD 5208/3906 rates
// [RULE_14] baud rates scale with system clock
// [RULE_15] first character zero or break: jump eeprom
// [RULE_16] idle timeout ends download, jump to ram
// [RULE_17] first character 55 at default: jump ram
// [RULE_18] bytes stored consecutively up to maximum length
package sbl_pkg;
   // bit periods in system clock cycles, so rates track the clock
   localparam logic [10:0] DIV_DEFAULT = 11'h100;
   localparam logic [10:0] DIV_1200 = 11'h680;
   localparam logic [10:0] DIV_9600 = 11'h0D0;
   localparam logic [10:0] DIV_5208 = 11'h180;
   localparam logic [10:0] DIV_3906 = 11'h200;
   // first low pulse width thresholds, halfway between candidates except THR_3906 (768, not 776)
   localparam logic [17:0] THR_DEFAULT = 18'h00140;
   localparam logic [17:0] THR_5208 = 18'h001C0;
   localparam logic [17:0] THR_3906 = 18'h00300;
   localparam logic [17:0] THR_9600 = 18'h00548;
   localparam logic [17:0] THR_1200 = 18'h007C0;
   // idle timeouts in bit times (ten bits to a character)
   localparam logic [7:0] TMO_BITS_FF = 8'h28;
   localparam logic [7:0] TMO_BITS_F0 = 8'h31;
   localparam logic [7:0] TMO_BITS_5208 = 8'hAD;
   localparam logic [7:0] TMO_BITS_3906 = 8'h82;
   localparam logic [7:0] CHAR_JUMP_RAM = 8'h55;
   localparam logic [9:0] MAX_LOAD = 10'h200;
   localparam logic [15:0] RAM_BASE = 16'h0000;
   localparam logic [15:0] EEPROM_BASE = 16'hB600;
   localparam logic [15:0] BOOT_ROM_LO = 16'hBF00;
   localparam logic [15:0] BOOT_ROM_HI = 16'hBFFF;
   localparam int MAP_EN_BIT = 7;
   localparam logic [3:0] FRAME_LAST = 4'h9;
endpackage : sbl_pkg

/* File: rtl/sbl_sci_tx.sv */
// double buffered serial transmitter for the echo path
`timescale 1ns/1ps
`default_nettype none
module sbl_sci_tx
(
   input wire logic ref_clk_in, // system clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic [10:0] period_in, // bit period in cycles
   input wire logic wr_in, // write the data register
   input wire logic [7:0] wdata_in, // character to send
   output logic hold_empty_out, // data register free
   output logic busy_out, // shifter active
   output logic txd_out // serial line, idle high
);
   logic [7:0] hold_ff;
   logic hold_full_ff;
   logic [9:0] shift_ff;
   logic [3:0] bit_ff;
   logic [10:0] baud_ff;
   logic busy_ff;
   logic load;

   assign load = hold_full_ff && !busy_ff;
   assign hold_empty_out = !hold_full_ff;
   assign busy_out = busy_ff;
   assign txd_out = shift_ff[0];

   // a write waits in the data register while the shifter drains
   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
         hold_full_ff <= 1'b0;
      else if (wr_in)
         hold_full_ff <= 1'b1; // RULE_09
      else if (load)
         hold_full_ff <= 1'b0;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
         hold_ff <= 8'h00;
      else if (wr_in && !hold_full_ff)
         hold_ff <= wdata_in;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         shift_ff <= 10'h3FF;
         bit_ff <= 4'h0;
         baud_ff <= 11'h000;
         busy_ff <= 1'b0;
      end
      else if (load)
      begin
         shift_ff <= {1'b1, hold_ff, 1'b0}; // RULE_09
         bit_ff <= 4'h0;
         baud_ff <= 11'h000;
         busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
         if (baud_ff == period_in - 11'h001)
         begin
            baud_ff <= 11'h000;
            shift_ff <= {1'b1, shift_ff[9:1]};
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == sbl_pkg::FRAME_LAST)
               busy_ff <= 1'b0;
         end
         else
            baud_ff <= baud_ff + 11'h001;
      end
   end
endmodule : sbl_sci_tx
`default_nettype wire

/* File: testbench/sbl_loader_chk.sv */
// port assertions for the serial boot download loader
`timescale 1ns/1ps
`default_nettype none
module sbl_loader_chk
(
   input wire logic ref_clk_in, // system clock
   input wire logic nrst_in, // reset, active low
   input wire logic mode_a_in, // mode pin a
   input wire logic mode_b_in, // mode pin b
   input wire logic txd_out, // serial transmit
   input wire logic jump_valid_out, // loader finished
   input wire logic [15:0] jump_addr_out, // start address
   input wire logic [9:0] load_count_out, // bytes stored
   input wire logic [7:0] mode_rdata_out, // mode register
   input wire logic [15:0] cpu_addr_in, // cpu address
   input wire logic [7:0] boot_rom_data_in, // boot rom data
   input wire logic [7:0] user_rom_data_in, // user rom data
   input wire logic boot_rom_sel_out, // boot rom selected
   input wire logic [7:0] cpu_rdata_out, // rom data
   input wire logic emulation_mode_out, // emulation active
   input wire logic emulation_output_enable_pin_in, // emulated oe
   input wire logic emu_data_oe_out // data pins driven
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   property p_reset_idle;
      disable iff (1'b0)
      !nrst_in |=> txd_out && !jump_valid_out && load_count_out == 10'h000;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs not idle in reset");
   property p_jump_hold;
      jump_valid_out |=> jump_valid_out && $stable(jump_addr_out);
   endproperty
   a_jump_hold: assert property (p_jump_hold)
      else $error("jump not held");
   property p_jump_addr;
      jump_valid_out |-> jump_addr_out == sbl_pkg::RAM_BASE
         || jump_addr_out == sbl_pkg::EEPROM_BASE;
   endproperty
   a_jump_addr: assert property (p_jump_addr)
      else $error("bad jump address");
   property p_count_step;
      $changed(load_count_out) |-> load_count_out ==
         $past(load_count_out) + 10'h001;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("load count skipped");
   property p_rom_sel;
      $past(nrst_in) |-> boot_rom_sel_out == (mode_rdata_out[7]
         && $past(cpu_addr_in[15:8]) == 8'hBF);
   endproperty
   a_rom_sel: assert property (p_rom_sel)
      else $error("boot rom select wrong");
   property p_rom_pick;
      $past(nrst_in) |-> cpu_rdata_out == (boot_rom_sel_out ?
         $past(boot_rom_data_in) : $past(user_rom_data_in));
   endproperty
   a_rom_pick: assert property (p_rom_pick)
      else $error("rom data source wrong");
   property p_emu_enter;
      disable iff (1'b0)
      (!nrst_in && !mode_a_in && !mode_b_in)[*5] |-> emulation_mode_out;
   endproperty
   a_emu_enter: assert property (p_emu_enter)
      else $error("emulation not entered");
   property p_emu_leave;
      disable iff (1'b0)
      nrst_in[*5] |-> !emulation_mode_out && !emu_data_oe_out;
   endproperty
   a_emu_leave: assert property (p_emu_leave)
      else $error("emulation outside reset");
   property p_emu_oe;
      disable iff (1'b0)
      (!nrst_in && !mode_a_in && !mode_b_in)[*6] |->
         emu_data_oe_out == !$past(emulation_output_enable_pin_in, 3);
   endproperty
   a_emu_oe: assert property (p_emu_oe)
      else $error("data pin drive wrong");
endmodule : sbl_loader_chk
`default_nettype wire

/* File: testbench/sbl_host_model.sv */
// host model: sends download characters and collects echoes
`timescale 1ns/1ps
`default_nettype none
module sbl_host_model
(
   input wire logic clk_in, // system clock
   input wire logic txd_in, // echo line from the device
   output logic rxd_out // line into the device, idle high
);
   int per = 256;
   logic [7:0] echo_q[$];
   logic [7:0] r;
   initial rxd_out = 1'b1;
   // streams without waiting for echoes, no gaps between chars
   task send(input logic [7:0] b, input int p);
      @(negedge clk_in);
      rxd_out = 1'b0;
      repeat (p) @(negedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
         rxd_out = b[i];
         repeat (p) @(negedge clk_in);
      end
      rxd_out = 1'b1;
      repeat (p) @(negedge clk_in);
   endtask : send
   task brk(input int n);
      @(negedge clk_in);
      rxd_out = 1'b0;
      repeat (n) @(negedge clk_in);
      rxd_out = 1'b1;
   endtask : brk
   always @(negedge txd_in)
   begin
      repeat (per / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
         repeat (per) @(posedge clk_in);
         r[i] = txd_in;
      end
      repeat (per) @(posedge clk_in);
      echo_q.push_back(r);
   end
endmodule : sbl_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the serial boot download loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0, ma = 1'b0, mb = 1'b0, mwr = 1'b0, oep = 1'b0;
   logic [8:0] ra = 9'h000;
   logic [7:0] mwd = 8'h00, brd = 8'hB1, urd = 8'h7E, ead = 8'h5C;
   logic [15:0] ca = 16'h0000;
   wire logic rxd, txd, jv, bsel, emu, eoe;
   wire logic [15:0] ja;
   wire logic [9:0] lc;
   wire logic [7:0] rd, mrd, crd, edo;
   int fails = 0, num_checks = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   sbl_loader sbl_loader_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .mode_a_in(ma), .mode_b_in(mb), .rxd_in(rxd), .txd_out(txd),
      .jump_valid_out(jv), .jump_addr_out(ja), .load_count_out(lc),
      .ram_rd_addr_in(ra), .ram_rd_data_out(rd), .mode_wr_in(mwr),
      .mode_wdata_in(mwd), .mode_rdata_out(mrd), .cpu_addr_in(ca),
      .boot_rom_data_in(brd), .user_rom_data_in(urd),
      .boot_rom_sel_out(bsel), .cpu_rdata_out(crd),
      .emulation_mode_out(emu), .emulation_output_enable_pin_in(oep),
      .emu_array_data_in(ead), .emu_data_out(edo), .emu_data_oe_out(eoe));
   sbl_host_model sbl_host_model_i (.clk_in(ref_clk_in), .txd_in(txd),
      .rxd_out(rxd));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task results;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task do_reset(input logic a, input logic b);
      @(negedge ref_clk_in);
      nrst_in = 1'b0;
      ma = a;
      mb = b;
      repeat (6) @(negedge ref_clk_in);
      nrst_in = 1'b1;
   endtask : do_reset
   task wait_jump(input int n);
      int k;
      k = 0;
      while (jv !== 1'b1 && k < n)
      begin
         @(negedge ref_clk_in);
         k++;
      end
      if (jv !== 1'b1)
      begin
         chk(jv, 16'h0001);
         results;
      end
   endtask : wait_jump
   // timeout runs from the last stop-bit sample, half a bit before the end
   task load(input logic [7:0] s, input int p, input int tb,
      input logic [7:0] d[$]);
      do_reset(1'b0, 1'b0);
      sbl_host_model_i.per = p;
      sbl_host_model_i.echo_q.delete();
      sbl_host_model_i.send(s, p);
      foreach (d[i]) sbl_host_model_i.send(d[i], p);
      repeat ((tb - 2) * p) @(negedge ref_clk_in);
      chk(jv, 16'h0000);
      wait_jump(3 * p);
      chk(ja, sbl_pkg::RAM_BASE);
      chk(lc, d.size());
      chk(sbl_host_model_i.echo_q.size(), d.size());
      foreach (d[i])
      begin
         ra = i;
         repeat (2) @(negedge ref_clk_in);
         chk(rd, d[i]);
         chk(sbl_host_model_i.echo_q[i], d[i]);
      end
   endtask : load
   task t_emulation;
      @(negedge ref_clk_in);
      nrst_in = 1'b0;
      repeat (6) @(negedge ref_clk_in);
      chk(emu, 16'h0001);
      chk(eoe, 16'h0001);
      chk(edo, ead);
      oep = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      chk(eoe, 16'h0000);
      nrst_in = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      chk(emu, 16'h0000);
   endtask : t_emulation
   task t_map;
      ca = 16'hBF10;
      repeat (2) @(negedge ref_clk_in);
      chk(mrd, 16'h0080);
      chk(crd, brd);
      ca = 16'hBEFF;
      repeat (2) @(negedge ref_clk_in);
      chk(crd, urd);
      mwr = 1'b1;
      @(negedge ref_clk_in);
      mwr = 1'b0;
      ca = 16'hBF10;
      repeat (3) @(negedge ref_clk_in);
      chk(mrd, 16'h0000);
      chk(crd, urd);
   endtask : t_map
   task t_protect;
      do_reset(1'b1, 1'b0);
      mwd = 8'h80;
      mwr = 1'b1;
      @(negedge ref_clk_in);
      mwr = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk(mrd, 16'h0000);
   endtask : t_protect
   // the long-timeout 5208 rate is cut short by a reset once the echo is back
   task t_fd;
      do_reset(1'b0, 1'b0);
      sbl_host_model_i.per = 384;
      sbl_host_model_i.echo_q.delete();
      sbl_host_model_i.send(8'hFD, 384);
      sbl_host_model_i.send(8'hC3, 384);
      repeat (11 * 384) @(negedge ref_clk_in);
      chk(jv, 16'h0000);
      chk(lc, 16'h0001);
      chk(sbl_host_model_i.echo_q.size(), 16'h0001);
      chk(sbl_host_model_i.echo_q[0], 16'h00C3);
      ra = 9'h000;
      repeat (2) @(negedge ref_clk_in);
      chk(rd, 16'h00C3);
   endtask : t_fd
   task t_jump_ram;
      do_reset(1'b0, 1'b0);
      repeat (50 * 256) @(negedge ref_clk_in);
      chk(jv, 16'h0000);
      sbl_host_model_i.send(sbl_pkg::CHAR_JUMP_RAM, 256);
      wait_jump(768);
      chk(ja, sbl_pkg::RAM_BASE);
      chk(lc, 16'h0000);
   endtask : t_jump_ram
   task t_eeprom;
      for (int i = 0; i < 2; i++)
      begin
         do_reset(1'b0, 1'b0);
         if (i == 0)
            sbl_host_model_i.send(8'h00, 256);
         else
            sbl_host_model_i.brk(5120);
         wait_jump(600);
         chk(ja, sbl_pkg::EEPROM_BASE);
      end
   endtask : t_eeprom
   initial
   begin
      fork
         begin
            repeat (99000) @(negedge ref_clk_in);
            chk(jv, 16'h0002);
            results;
         end
      join_none
      do_reset(1'b0, 1'b0);
      t_emulation();
      t_map();
      load(8'hFF, 256, 40, '{8'hA5, 8'h3C, 8'h00});
      load(8'hF0, 208, 49, '{8'h5A});
      t_fd();
      t_jump_ram();
      t_eeprom();
      t_protect();
      results;
   end
endmodule : testbench
bind sbl_loader sbl_loader_chk sbl_loader_chk_i (.ref_clk_in(ref_clk_in),
   .nrst_in(nrst_in), .mode_a_in(mode_a_in), .mode_b_in(mode_b_in),
   .txd_out(txd_out), .jump_valid_out(jump_valid_out),
   .jump_addr_out(jump_addr_out), .load_count_out(load_count_out),
   .mode_rdata_out(mode_rdata_out), .cpu_addr_in(cpu_addr_in),
   .boot_rom_data_in(boot_rom_data_in),
   .user_rom_data_in(user_rom_data_in),
   .boot_rom_sel_out(boot_rom_sel_out), .cpu_rdata_out(cpu_rdata_out),
   .emulation_mode_out(emulation_mode_out),
   .emulation_output_enable_pin_in(emulation_output_enable_pin_in),
   .emu_data_oe_out(emu_data_oe_out));
`default_nettype wire
